// ---- hdl/dtc_pkg.sv ----
/*
 * constants, types and field layout for the dual timer/counter block.
 * assumes a byte-wide special-function register port and one core clock.
 */
package dtc_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] DTC_ADDR_CTRL  = 8'h88;
	localparam logic [7:0] DTC_ADDR_MODE  = 8'h89;
	localparam logic [7:0] DTC_ADDR_A_LO  = 8'h8a;
	localparam logic [7:0] DTC_ADDR_B_LO  = 8'h8b;
	localparam logic [7:0] DTC_ADDR_A_HI  = 8'h8c;
	localparam logic [7:0] DTC_ADDR_B_HI  = 8'h8d;
	localparam logic [4:0] DTC_BIT_BLOCK  = 5'h11;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] DTC_CTRL_RST   = 8'h00;
	localparam logic [7:0] DTC_MODE_RST   = 8'h00;
	localparam logic [7:0] DTC_COUNT_RST  = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DTC_B_OVF_BIT  = 7;
	localparam int DTC_B_RUN_BIT  = 6;
	localparam int DTC_A_OVF_BIT  = 5;
	localparam int DTC_A_RUN_BIT  = 4;
	localparam int DTC_B_CFG_LSB  = 4;
	localparam int DTC_A_CFG_LSB  = 0;

	// ----------------------------------------------------------------
	// machine cycle timing, in core clocks
	// ----------------------------------------------------------------
	localparam logic [3:0] DTC_MC_LAST      = 4'hb;
	localparam logic [3:0] DTC_PHASE_SAMPLE = 4'h9;
	localparam logic [3:0] DTC_PHASE_UPDATE = 4'h4;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD8,
		DTC_MODE_SPLIT
	} dtc_mode_e;

	typedef struct packed {
		logic      gate;
		logic      ctr_sel;
		dtc_mode_e mode;
	} dtc_cfg_s;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       bit_wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       bit_val;
	} dtc_sfr_req_s;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} dtc_count_s;

endpackage : dtc_pkg

// ---- hdl/dtc_timer.sv ----
/*
 * two timer/counter units sharing one mode and one control register.
 * assumes the core drives one special-function access per clock and that
 * count and gate pins are already synchronous to clock.
 */
`timescale 1ns/1ps

module dtc_timer (
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire dtc_pkg::dtc_sfr_req_s sfr_req,
	output logic       [7:0]           sfr_rdata,
	input  wire logic                  count_pin_a,
	input  wire logic                  count_pin_b,
	input  wire logic                  ext_irq_pin_a,
	input  wire logic                  ext_irq_pin_b,
	input  wire logic                  vector_ack_a,
	input  wire logic                  vector_ack_b,
	output logic                       ctr_a_ovf_flag,
	output logic                       ctr_b_ovf_flag
);
	import dtc_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] dtc_inc8(input logic [7:0] v);
		dtc_inc8 = {1'b0, v} + 9'h001;
	endfunction : dtc_inc8

	// returns {overflow, high, low} after one count
	function automatic logic [16:0] dtc_step(input dtc_mode_e m, input dtc_count_s c);
		logic [5:0]  l5;
		logic [8:0]  h9;
		logic [16:0] s17;
		l5  = 6'h00;
		h9  = 9'h000;
		s17 = 17'h0_0000;

		case (m)
			DTC_MODE_13BIT: begin
				l5 = {1'b0, c.lo[4:0]} + 6'h01;
				h9 = {1'b0, c.hi} + {8'h00, l5[5]};
				dtc_step = {h9[8], h9[7:0], c.lo[7:5], l5[4:0]};
			end
			DTC_MODE_16BIT: begin
				s17 = {1'b0, c.hi, c.lo} + 17'h0_0001;
				dtc_step = s17;
			end
			DTC_MODE_RELOAD8: begin
				h9 = dtc_inc8(c.lo);
				dtc_step = h9[8] ? {1'b1, c.hi, c.hi} : {1'b0, c.hi, h9[7:0]};
			end
			default: begin
				dtc_step = {1'b0, c.hi, c.lo};
			end
		endcase
	endfunction : dtc_step

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [3:0]  phase_q,  phase_d;
	logic        samp_a_q, samp_a_d;
	logic        samp_b_q, samp_b_d;
	logic        pend_a_q, pend_a_d;
	logic        pend_b_q, pend_b_d;

	logic [7:0]  ctrl_q,   ctrl_d;
	logic [7:0]  mode_q,   mode_d;

	dtc_count_s  cnt_a_q,  cnt_a_d;
	dtc_count_s  cnt_b_q,  cnt_b_d;

	logic [7:0]  rdata_q,  rdata_d;

	dtc_cfg_s    cfg_a;
	dtc_cfg_s    cfg_b;

	logic        update;
	logic        sample;

	logic        run_a;
	logic        run_b;
	logic        tick_a;
	logic        tick_b;
	logic        tick_a_hi;

	logic        set_a;
	logic        set_b;
	logic [16:0] step_a;
	logic [16:0] step_b;

	logic [8:0]  inc_a_lo;
	logic [8:0]  inc_a_hi;

	logic        bit_hit;
	logic [7:0]  bit_mask;

	assign cfg_a = dtc_cfg_s'(mode_q[DTC_A_CFG_LSB +: 4]);
	assign cfg_b = dtc_cfg_s'(mode_q[DTC_B_CFG_LSB +: 4]);

	// ----------------------------------------------------------------
	// machine cycle and pin sampling
	// ----------------------------------------------------------------
	always_comb begin
		phase_d  = (phase_q == DTC_MC_LAST) ? 4'h0 : phase_q + 4'h1;

		sample   = (phase_q == DTC_PHASE_SAMPLE);
		update   = (phase_q == DTC_PHASE_UPDATE);

		samp_a_d = sample ? count_pin_a : samp_a_q;
		samp_b_d = sample ? count_pin_b : samp_b_q;

		pend_a_d = pend_a_q;
		pend_b_d = pend_b_q;

		if (update) begin
			pend_a_d = 1'b0;
			pend_b_d = 1'b0;
		end

		if (sample && samp_a_q && !count_pin_a) begin
			pend_a_d = 1'b1;
		end

		if (sample && samp_b_q && !count_pin_b) begin
			pend_b_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			phase_q  <= 4'h0;
			samp_a_q <= 1'b0;
			samp_b_q <= 1'b0;
			pend_a_q <= 1'b0;
			pend_b_q <= 1'b0;
		end else begin
			phase_q  <= phase_d;
			samp_a_q <= samp_a_d;
			samp_b_q <= samp_b_d;
			pend_a_q <= pend_a_d;
			pend_b_q <= pend_b_d;
		end
	end

	// ----------------------------------------------------------------
	// count enables
	// ----------------------------------------------------------------
	always_comb begin
		run_a  = ctrl_q[DTC_A_RUN_BIT] && (!cfg_a.gate || ext_irq_pin_a);
		run_b  = ctrl_q[DTC_B_RUN_BIT] && (!cfg_b.gate || ext_irq_pin_b);

		tick_a = update && run_a && (cfg_a.ctr_sel ? pend_a_q : 1'b1);

		tick_b = update && run_b && (cfg_b.ctr_sel ? pend_b_q : 1'b1)
			&& (cfg_b.mode != DTC_MODE_SPLIT);

		tick_a_hi = update && ctrl_q[DTC_B_RUN_BIT];
	end

	// ----------------------------------------------------------------
	// counters and flags
	// ----------------------------------------------------------------
	always_comb begin
		step_a   = dtc_step(cfg_a.mode, cnt_a_q);
		step_b   = dtc_step(cfg_b.mode, cnt_b_q);
		inc_a_lo = dtc_inc8(cnt_a_q.lo);
		inc_a_hi = dtc_inc8(cnt_a_q.hi);

		cnt_a_d  = cnt_a_q;
		cnt_b_d  = cnt_b_q;

		set_a    = 1'b0;
		set_b    = 1'b0;

		if (cfg_a.mode == DTC_MODE_SPLIT) begin
			if (tick_a) begin
				cnt_a_d.lo = inc_a_lo[7:0];
				set_a      = inc_a_lo[8];
			end
			if (tick_a_hi) begin
				cnt_a_d.hi = inc_a_hi[7:0];
				set_b      = inc_a_hi[8];
			end
		end else if (tick_a) begin
			cnt_a_d = dtc_count_s'(step_a[15:0]);
			set_a   = step_a[16];
		end

		if (tick_b) begin
			cnt_b_d = dtc_count_s'(step_b[15:0]);
			if (cfg_a.mode != DTC_MODE_SPLIT) begin
				set_b = step_b[16];
			end
		end

		// software write wins over hardware count
		if (sfr_req.wr) begin
			case (sfr_req.addr)
				DTC_ADDR_A_LO: cnt_a_d.lo = sfr_req.wdata;
				DTC_ADDR_A_HI: cnt_a_d.hi = sfr_req.wdata;
				DTC_ADDR_B_LO: cnt_b_d.lo = sfr_req.wdata;
				DTC_ADDR_B_HI: cnt_b_d.hi = sfr_req.wdata;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// control and mode registers
	// ----------------------------------------------------------------
	always_comb begin
		bit_hit  = sfr_req.bit_wr && (sfr_req.addr[7:3] == DTC_BIT_BLOCK);
		bit_mask = 8'h01 << sfr_req.addr[2:0];

		ctrl_d   = ctrl_q;
		mode_d   = mode_q;

		if (sfr_req.wr && sfr_req.addr == DTC_ADDR_MODE) begin
			mode_d = sfr_req.wdata;
		end

		if (vector_ack_a) begin
			ctrl_d[DTC_A_OVF_BIT] = 1'b0;
		end

		if (vector_ack_b) begin
			ctrl_d[DTC_B_OVF_BIT] = 1'b0;
		end

		if (sfr_req.wr && sfr_req.addr == DTC_ADDR_CTRL) begin
			ctrl_d = sfr_req.wdata;
		end else if (bit_hit) begin
			ctrl_d = sfr_req.bit_val ? (ctrl_q | bit_mask) : (ctrl_q & ~bit_mask);
		end

		if (set_a) begin
			ctrl_d[DTC_A_OVF_BIT] = 1'b1;
		end

		if (set_b) begin
			ctrl_d[DTC_B_OVF_BIT] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = rdata_q;

		if (sfr_req.rd) begin
			case (sfr_req.addr)
				DTC_ADDR_CTRL: rdata_d = ctrl_q;
				DTC_ADDR_MODE: rdata_d = mode_q;
				DTC_ADDR_A_LO: rdata_d = cnt_a_q.lo;
				DTC_ADDR_A_HI: rdata_d = cnt_a_q.hi;
				DTC_ADDR_B_LO: rdata_d = cnt_b_q.lo;
				DTC_ADDR_B_HI: rdata_d = cnt_b_q.hi;
				default:       rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_q  <= DTC_CTRL_RST;
			mode_q  <= DTC_MODE_RST;
			cnt_a_q <= {DTC_COUNT_RST, DTC_COUNT_RST};
			cnt_b_q <= {DTC_COUNT_RST, DTC_COUNT_RST};
			rdata_q <= 8'h00;
		end else begin
			ctrl_q  <= ctrl_d;
			mode_q  <= mode_d;
			cnt_a_q <= cnt_a_d;
			cnt_b_q <= cnt_b_d;
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata      = rdata_q;
	assign ctr_a_ovf_flag = ctrl_q[DTC_A_OVF_BIT];
	assign ctr_b_ovf_flag = ctrl_q[DTC_B_OVF_BIT];

endmodule : dtc_timer

// ---- sim/dtc_timer_props.sv ----
/* port checker for the dual timer/counter.
 * bound to dtc_timer from the testbench top file. */
`timescale 1ns/1ps
module dtc_timer_props (
	input wire logic                  clock,
	input wire logic                  srst,
	input wire dtc_pkg::dtc_sfr_req_s sfr_req,
	input wire logic [7:0]            sfr_rdata,
	input wire logic                  count_pin_a,
	input wire logic                  count_pin_b,
	input wire logic                  ext_irq_pin_a,
	input wire logic                  ext_irq_pin_b,
	input wire logic                  vector_ack_a,
	input wire logic                  vector_ack_b,
	input wire logic                  ctr_a_ovf_flag,
	input wire logic                  ctr_b_ovf_flag
);
	import dtc_pkg::*;
	// ------------------------------------------------
	// machine cycle phase
	// ------------------------------------------------
	logic [3:0] ph_q;
	logic       upd;
	logic       sw;
	always_ff @(posedge clock) ph_q <= (srst || ph_q == DTC_MC_LAST) ? 4'h0 : ph_q + 4'h1;
	assign upd = ph_q == DTC_PHASE_UPDATE;
	assign sw  = sfr_req.wr | sfr_req.bit_wr;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	reset_vals_a: assert property ($past(srst) |-> sfr_rdata == 8'h00 && !ctr_a_ovf_flag
		&& !ctr_b_ovf_flag) else $error("state not cleared by reset");
	unmapped_rd_a: assert property (sfr_req.rd && !(sfr_req.addr inside {[8'h88:8'h8d]})
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	bit_set_a: assert property (sfr_req.bit_wr && !sfr_req.wr && sfr_req.addr == 8'h8d
		&& sfr_req.bit_val |=> ctr_a_ovf_flag) else $error("bit write did not set flag");
	byte_wr_a: assert property (sfr_req.wr && sfr_req.addr == DTC_ADDR_CTRL
		&& (sfr_req.wdata[7] || !upd) |=> ctr_b_ovf_flag == $past(sfr_req.wdata[7]))
		else $error("control byte write not stored");
	rise_a_a: assert property ($rose(ctr_a_ovf_flag) |-> $past(upd) || $past(sw))
		else $error("flag a rose off the update phase");
	rise_b_a: assert property ($rose(ctr_b_ovf_flag) |-> $past(upd) || $past(sw))
		else $error("flag b rose off the update phase");
	ack_a_a: assert property (vector_ack_a && !upd && !sw |=> !ctr_a_ovf_flag)
		else $error("ack did not clear flag a");
	ack_b_a: assert property (vector_ack_b && !upd && !sw |=> !ctr_b_ovf_flag)
		else $error("ack did not clear flag b");
	hold_a_a: assert property (ctr_a_ovf_flag && !vector_ack_a && !sw |=> ctr_a_ovf_flag)
		else $error("flag a dropped by itself");
endmodule : dtc_timer_props

// ---- sim/dtc_pin_model.sv ----
/* far side model: count pin pulses and gate levels.
 * driven by the testbench through go, sel, num, irq_a_lvl and irq_b_lvl. */
`timescale 1ns/1ps
module dtc_pin_model (
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic       sel,
	input  wire logic [7:0] num,
	input  wire logic       irq_a_lvl,
	input  wire logic       irq_b_lvl,
	output logic            busy,
	output logic            count_pin_a,
	output logic            count_pin_b,
	output logic            ext_irq_pin_a,
	output logic            ext_irq_pin_b
);
	logic [1:0] pin_q = 2'b00;
	assign count_pin_a   = pin_q[0];
	assign count_pin_b   = pin_q[1];
	assign ext_irq_pin_a = irq_a_lvl;
	assign ext_irq_pin_b = irq_b_lvl;
	always begin
		busy = 1'b0;
		@(posedge clock);
		if (go) begin
			busy = 1'b1;
			repeat (num) begin
				repeat (12) @(posedge clock);
				pin_q[sel] <= 1'b1;
				repeat (12) @(posedge clock);
				pin_q[sel] <= 1'b0;
			end
			repeat (12) @(posedge clock);
		end
	end
endmodule : dtc_pin_model

// ---- sim/tb_dtc_timer.sv ----
/* testbench for the dual timer/counter.
 * uses dtc_pin_model on the pins and the bound port checker. */
`timescale 1ns/1ps
module tb_dtc_timer;
	import dtc_pkg::*;
	logic         clock = 1'b0;
	logic         srst, go, sel, irq_a_lvl, irq_b_lvl, busy;
	logic [7:0]   num, sfr_rdata;
	dtc_sfr_req_s sfr_req;
	logic         count_pin_a, count_pin_b, ext_irq_pin_a, ext_irq_pin_b;
	logic         vector_ack_a, vector_ack_b, ctr_a_ovf_flag, ctr_b_ovf_flag;
	int           errors = 0;
	int           check_count = 0;
	logic [7:0]   tv [3][6] = '{'{8'hff, 8'hfe, 8'h01, 8'h1e, 8'h00, 8'h02},
		'{8'hff, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h80, 8'hff, 8'h02, 8'h00, 8'h80, 8'h80}};
	always #2 clock = ~clock;
	dtc_timer uut (.clock, .srst, .sfr_req, .sfr_rdata, .count_pin_a, .count_pin_b,
		.ext_irq_pin_a, .ext_irq_pin_b, .vector_ack_a, .vector_ack_b, .ctr_a_ovf_flag,
		.ctr_b_ovf_flag);
	dtc_pin_model u_pins (.clock, .go, .sel, .num, .irq_a_lvl, .irq_b_lvl, .busy,
		.count_pin_a, .count_pin_b, .ext_irq_pin_a, .ext_irq_pin_b);
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task summarize;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic acc(input logic w, r, b, input logic [7:0] a, d, input logic v);
		@(posedge clock);
		sfr_req <= '{w, r, b, a, d, v};
		@(posedge clock);
		sfr_req <= '0;
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, 1'b0, 1'b0, a, d, 1'b0);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, 1'b1, 1'b0, a, 8'h00, 1'b0);
		#1;
		chk(sfr_rdata, e);
	endtask : rd_chk
	task automatic ack(input logic b);
		@(posedge clock);
		if (b) vector_ack_b <= 1'b1; else vector_ack_a <= 1'b1;
		@(posedge clock);
		vector_ack_a <= 1'b0;
		vector_ack_b <= 1'b0;
		#1;
	endtask : ack
	task automatic wait_flag(input logic b);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge clock);
			#1;
			if ((b ? ctr_b_ovf_flag : ctr_a_ovf_flag) === 1'b1) break;
		end
		if (i == 200) begin
			errors++;
			summarize();
		end
	endtask : wait_flag
	task automatic pulses(input logic [7:0] n);
		int i;
		@(posedge clock);
		go <= 1'b1;
		num <= n;
		@(posedge clock);
		go <= 1'b0;
		#1;
		for (i = 0; i < 2000 && busy !== 1'b0; i++) begin
			@(posedge clock);
			#1;
		end
		if (i == 2000) begin
			errors++;
			summarize();
		end
		repeat (24) @(posedge clock);
	endtask : pulses
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		{go, irq_a_lvl, irq_b_lvl, vector_ack_a, vector_ack_b} = 5'h00;
		sel = 1'b1;
		num = 8'h00;
		sfr_req = '0;
		srst = 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		rd_chk(DTC_ADDR_CTRL, DTC_CTRL_RST);
		rd_chk(DTC_ADDR_MODE, DTC_MODE_RST);
		rd_chk(DTC_ADDR_B_HI, DTC_COUNT_RST);
		rd_chk(8'h80, 8'h00);
		wr(DTC_ADDR_MODE, 8'h5a);
		acc(1'b0, 1'b0, 1'b1, 8'h89, 8'h00, 1'b1);
		rd_chk(DTC_ADDR_MODE, 8'h5a);
		rd_chk(DTC_ADDR_CTRL, 8'h02);
		acc(1'b0, 1'b0, 1'b1, 8'h8d, 8'h00, 1'b1);
		#1;
		chk({7'h00, ctr_a_ovf_flag}, 8'h01);
		ack(1'b0);
		chk({7'h00, ctr_a_ovf_flag}, 8'h00);
		for (int k = 0; k < 3; k++) begin
			wr(DTC_ADDR_CTRL, 8'h00);
			wr(DTC_ADDR_MODE, tv[k][2]);
			wr(DTC_ADDR_A_HI, tv[k][0]);
			wr(DTC_ADDR_A_LO, tv[k][1]);
			wr(DTC_ADDR_CTRL, 8'h10);
			wait_flag(1'b0);
			repeat (tv[k][3]) @(posedge clock);
			wr(DTC_ADDR_CTRL, 8'h20);
			rd_chk(DTC_ADDR_A_HI, tv[k][4]);
			rd_chk(DTC_ADDR_A_LO, tv[k][5]);
			ack(1'b0);
			chk({7'h00, ctr_a_ovf_flag}, 8'h00);
		end
		wr(DTC_ADDR_MODE, 8'h50);
		wr(DTC_ADDR_B_LO, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h40);
		pulses(8'h03);
		rd_chk(DTC_ADDR_B_LO, 8'h03);
		wr(DTC_ADDR_MODE, 8'hd0);
		pulses(8'h03);
		rd_chk(DTC_ADDR_B_LO, 8'h03);
		@(posedge clock) irq_b_lvl <= 1'b1;
		pulses(8'h02);
		rd_chk(DTC_ADDR_B_LO, 8'h05);
		wr(DTC_ADDR_CTRL, 8'h00);
		wr(DTC_ADDR_A_HI, 8'hff);
		wr(DTC_ADDR_A_LO, 8'h00);
		wr(DTC_ADDR_MODE, 8'h33);
		wr(DTC_ADDR_CTRL, 8'h40);
		wait_flag(1'b1);
		rd_chk(DTC_ADDR_A_HI, 8'h00);
		rd_chk(DTC_ADDR_A_LO, 8'h00);
		rd_chk(DTC_ADDR_B_LO, 8'h05);
		chk({7'h00, ctr_a_ovf_flag}, 8'h00);
		ack(1'b1);
		chk({7'h00, ctr_b_ovf_flag}, 8'h00);
		summarize();
	end
endmodule : tb_dtc_timer

bind dtc_timer dtc_timer_props u_props (.clock, .srst, .sfr_req, .sfr_rdata, .count_pin_a,
	.count_pin_b, .ext_irq_pin_a, .ext_irq_pin_b, .vector_ack_a, .vector_ack_b,
	.ctr_a_ovf_flag, .ctr_b_ovf_flag);
